// ### include/exec_consts.svh
// Register offsets, field positions, reset values of the call and compare execution block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

`define ADR_OPND_A      8'h00
`define ADR_OPND_B      8'h04
`define ADR_TARGET      8'h08
`define ADR_SEGMENT     8'h0C
`define ADR_STACK_PTR   8'h10
`define ADR_INSTR_PTR   8'h14
`define ADR_CODE_SEG    8'h18
`define ADR_COMMAND     8'h1C
`define ADR_STATUS      8'h20

`define CMD_OP_LSB      0
`define CMD_OP_MSB      2
`define CMD_COND_BIT    3
`define CMD_PRED_BIT    4
`define CMD_DISP_LSB    8
`define CMD_DISP_MSB    15

`define FLG_E           4
`define FLG_Z           3
`define FLG_V           2
`define FLG_C           1
`define FLG_N           0
`define STS_BUSY        8
`define STS_TAKEN       9
`define STS_MISPRED     10

`define RST_WORD        16'h0000
`define RST_FLAGS       5'h00
`define STACK_STEP      16'h0002
`define WORD_MIN_NEG    16'h8000
`define BYTE_MIN_NEG    8'h80

`endif

// ### include/exec_pkg.sv
// Types shared by the call and compare execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package exec_pkg;

   typedef enum logic [2:0] {
      OP_BIT_XOR,
      OP_CALL_ABS,
      OP_CALL_IND,
      OP_CALL_REL,
      OP_CALL_SEG,
      OP_COMPARE_WORD,
      OP_COMPARE_BYTE,
      OP_NONE
   } opcode_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_PUSH2
   } state_e;

endpackage

// ### src/call_and_compare_execution.sv
// Execution unit for single-bit XOR, four subroutine call_intersegment and word/byte compare.
// Assumes a classic Wishbone master; condition codes are evaluated outside and
// handed in as one bit; stack pushes leave through a one-word write port.
//
// Summary of operation
// - Bit XOR clears E and sets Z=NOR, V=OR, C=AND, N=XOR of both bits.
// - Bit XOR writes source XOR destination back into the destination bit.
// - Absolute call if condition true: stack down 2, push pointer, load target.
// - Absolute call holds a prediction bit: clear predicts taken, set predicts not taken.
// - Indirect call if condition true: stack down 2, push pointer, jump to target.
// - Relative call always pushes, then adds twice the sign-extended 8-bit displacement.
// - Relative target is based on the address of the following instruction.
// - Every taken call pushes the pointer, which already addresses the next instruction.
// - Segment call pushes segment then pointer, then loads new segment and offset.
// - Word compare subtracts second from first, sets flags, writes no result.
// - Byte compare does the same subtraction on bytes, leaving operands intact.
// - Compare sets E when the second operand is the most negative value.
// - Compare sets Z on zero result and N on result sign bit.
// - Word compare sets V when the result overflows a signed word.
// - Compare sets C on a borrow out of the top bit.
// - Byte compare sets V when the result overflows a signed byte.
`timescale 1ns/1ps
`include "exec_consts.svh"

module call_and_compare_execution #(
   parameter int SEG_W = 8                            // Code segment number width
) (
   input  wire logic        I_SYS_CLK,                // 25 MHz system clock
   input  wire logic        I_RST,                    // Asynchronous reset, active high
   input  wire logic        I_WB_CYC,                 // Wishbone cycle
   input  wire logic        I_WB_STB,                 // Wishbone strobe
   input  wire logic        I_WB_WE,                  // Wishbone write enable
   input  wire logic [7:0]  I_WB_ADR,                 // Wishbone byte address
   input  wire logic [3:0]  I_WB_SEL,                 // Wishbone byte select
   input  wire logic [31:0] I_WB_DAT,                 // Wishbone write data
   output logic      [31:0] O_WB_DAT,                 // Wishbone read data
   output logic             O_WB_ACK,                 // Wishbone acknowledge
   output logic             O_STK_WE,                 // Stack word write strobe
   output logic      [15:0] O_STK_ADR,                // Stack word byte address
   output logic      [15:0] O_STK_DAT,                // Stack word data
   output logic             O_BUSY                    // Instruction in progress
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) r[7:0]  = dat[7:0];
      if (sel[1]) r[15:8] = dat[15:8];
      return r;
   endfunction

   // Flags E Z V C N of op1 - op2 at word or byte width
   function automatic logic [4:0] compare_flags(input logic [15:0] a,
                                                input logic [15:0] b,
                                                input logic        byte_mode);
      logic [16:0] dw;
      logic [8:0]  db;
      logic [4:0]  f;
      dw = {1'b0, a} - {1'b0, b};
      db = {1'b0, a[7:0]} - {1'b0, b[7:0]};
      if (byte_mode) begin
         f[`FLG_E] = (b[7:0] == `BYTE_MIN_NEG);
         f[`FLG_Z] = (db[7:0] == 8'h00);
         f[`FLG_V] = (a[7] != b[7]) && (db[7] != a[7]);
         f[`FLG_C] = db[8];
         f[`FLG_N] = db[7];
      end else begin
         f[`FLG_E] = (b == `WORD_MIN_NEG);
         f[`FLG_Z] = (dw[15:0] == 16'h0000);
         f[`FLG_V] = (a[15] != b[15]) && (dw[15] != a[15]);
         f[`FLG_C] = dw[16];
         f[`FLG_N] = dw[15];
      end
      return f;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   exec_pkg::state_e  state;
   exec_pkg::opcode_e op;
   logic [15:0]       opnd_a;
   logic [15:0]       opnd_b;
   logic [15:0]       target;
   logic [SEG_W-1:0]  segment;
   logic [15:0]       stack_ptr;
   logic [15:0]       instr_pointer;
   logic [SEG_W-1:0]  code_segment_pointer;
   logic [15:0]       command;
   logic [4:0]        flags;
   logic              taken;
   logic              mispred;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   // A write lands at the edge where the master sees ack, and not before
   wire         bus_req   = I_WB_CYC && I_WB_STB;
   wire         wr_fire   = bus_req && I_WB_WE && O_WB_ACK;
   wire         idle      = (state == exec_pkg::ST_IDLE);
   wire         wr_a      = wr_fire && idle && (I_WB_ADR == `ADR_OPND_A);
   wire         wr_b      = wr_fire && idle && (I_WB_ADR == `ADR_OPND_B);
   wire         wr_tgt    = wr_fire && idle && (I_WB_ADR == `ADR_TARGET);
   wire         wr_seg    = wr_fire && idle && (I_WB_ADR == `ADR_SEGMENT);
   wire         wr_stk    = wr_fire && idle && (I_WB_ADR == `ADR_STACK_PTR);
   wire         wr_instr  = wr_fire && idle && (I_WB_ADR == `ADR_INSTR_PTR);
   wire         wr_cseg   = wr_fire && idle && (I_WB_ADR == `ADR_CODE_SEG);
   // Command is only taken whole: a partial write would launch a half-built op
   wire         go        = wr_fire && idle && (I_WB_ADR == `ADR_COMMAND)
                            && (I_WB_SEL[1:0] == 2'h3);
   wire [15:0]  seg_word  = 16'(code_segment_pointer);
   wire [31:0]  status    = {21'h000000, mispred, taken, !idle, 3'h0, flags};
   wire [15:0]  stk_dec   = stack_ptr - `STACK_STEP;
   wire [7:0]   disp      = command[`CMD_DISP_MSB:`CMD_DISP_LSB];
   wire [15:0]  rel_off   = {{7{disp[7]}}, disp, 1'b0};
   wire         cond      = command[`CMD_COND_BIT];
   wire         pred_nt   = command[`CMD_PRED_BIT];
   wire [4:0]   xor_flags = {1'b0, !(opnd_a[0] | opnd_b[0]), opnd_a[0] | opnd_b[0],
                             opnd_a[0] & opnd_b[0], opnd_a[0] ^ opnd_b[0]};
   wire         is_cond   = (op == exec_pkg::OP_CALL_ABS) || (op == exec_pkg::OP_CALL_IND);
   wire         is_call   = is_cond || (op == exec_pkg::OP_CALL_REL)
                            || (op == exec_pkg::OP_CALL_SEG);

   logic [31:0] rd_mux;
   always_comb begin
      unique case (I_WB_ADR)
         `ADR_OPND_A:    rd_mux = {16'h0000, opnd_a};
         `ADR_OPND_B:    rd_mux = {16'h0000, opnd_b};
         `ADR_TARGET:    rd_mux = {16'h0000, target};
         `ADR_SEGMENT:   rd_mux = {16'h0000, 16'(segment)};
         `ADR_STACK_PTR: rd_mux = {16'h0000, stack_ptr};
         `ADR_INSTR_PTR: rd_mux = {16'h0000, instr_pointer};
         `ADR_CODE_SEG:  rd_mux = {16'h0000, seg_word};
         `ADR_COMMAND:   rd_mux = {16'h0000, command};
         `ADR_STATUS:    rd_mux = status;
         default:        rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h00000000;
      end else begin
         O_WB_ACK <= bus_req && !O_WB_ACK;
         O_WB_DAT <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operand and command registers

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         opnd_b  <= `RST_WORD;
         target  <= `RST_WORD;
         segment <= '0;
         command <= `RST_WORD;
         op      <= exec_pkg::OP_NONE;
      end else begin
         if (wr_b)   opnd_b  <= merge16(opnd_b, I_WB_DAT, I_WB_SEL);
         if (wr_tgt) target  <= merge16(target, I_WB_DAT, I_WB_SEL);
         if (wr_seg) segment <= SEG_W'(merge16(16'(segment), I_WB_DAT, I_WB_SEL));
         if (go) begin
            command <= I_WB_DAT[15:0];
            op      <= exec_pkg::opcode_e'(I_WB_DAT[`CMD_OP_MSB:`CMD_OP_LSB]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Execution

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         state                <= exec_pkg::ST_IDLE;
         opnd_a               <= `RST_WORD;
         stack_ptr            <= `RST_WORD;
         instr_pointer        <= `RST_WORD;
         code_segment_pointer <= '0;
         flags                <= `RST_FLAGS;
         taken                <= 1'b0;
         mispred              <= 1'b0;
         O_STK_WE             <= 1'b0;
         O_STK_ADR            <= `RST_WORD;
         O_STK_DAT            <= `RST_WORD;
         O_BUSY               <= 1'b0;
      end else begin
         O_STK_WE <= 1'b0;
         if (wr_a)   opnd_a        <= merge16(opnd_a, I_WB_DAT, I_WB_SEL);
         if (wr_stk)   stack_ptr     <= merge16(stack_ptr, I_WB_DAT, I_WB_SEL);
         if (wr_instr) instr_pointer <= merge16(instr_pointer, I_WB_DAT, I_WB_SEL);
         if (wr_cseg)  code_segment_pointer <= SEG_W'(merge16(seg_word, I_WB_DAT, I_WB_SEL));
         unique case (state)
            exec_pkg::ST_IDLE: begin
               if (go) begin
                  state  <= exec_pkg::ST_EXEC;
                  O_BUSY <= 1'b1;
               end
            end
            exec_pkg::ST_EXEC: begin
               state  <= exec_pkg::ST_IDLE;
               O_BUSY <= 1'b0;
               unique case (op)
                  exec_pkg::OP_BIT_XOR: begin
                     flags     <= xor_flags;
                     opnd_a[0] <= opnd_a[0] ^ opnd_b[0];
                  end
                  exec_pkg::OP_COMPARE_WORD:
                     flags <= compare_flags(opnd_a, opnd_b, 1'b0);
                  exec_pkg::OP_COMPARE_BYTE:
                     flags <= compare_flags(opnd_a, opnd_b, 1'b1);
                  exec_pkg::OP_CALL_ABS,
                  exec_pkg::OP_CALL_IND: begin
                     taken   <= cond;
                     // Prediction only scored here; fetch lives elsewhere
                     mispred <= (op == exec_pkg::OP_CALL_ABS) && (cond == pred_nt);
                     if (cond) begin
                        stack_ptr     <= stk_dec;
                        O_STK_WE      <= 1'b1;
                        O_STK_ADR     <= stk_dec;
                        O_STK_DAT     <= instr_pointer;
                        instr_pointer <= target;
                     end
                  end
                  exec_pkg::OP_CALL_REL: begin
                     taken         <= 1'b1;
                     mispred       <= 1'b0;
                     stack_ptr     <= stk_dec;
                     O_STK_WE      <= 1'b1;
                     O_STK_ADR     <= stk_dec;
                     O_STK_DAT     <= instr_pointer;
                     instr_pointer <= instr_pointer + rel_off;
                  end
                  exec_pkg::OP_CALL_SEG: begin
                     taken     <= 1'b1;
                     mispred   <= 1'b0;
                     state     <= exec_pkg::ST_PUSH2;
                     O_BUSY    <= 1'b1;
                     stack_ptr <= stk_dec;
                     O_STK_WE  <= 1'b1;
                     O_STK_ADR <= stk_dec;
                     O_STK_DAT <= seg_word;
                  end
                  default: ;
               endcase
            end
            exec_pkg::ST_PUSH2: begin
               state                <= exec_pkg::ST_IDLE;
               O_BUSY               <= 1'b0;
               stack_ptr            <= stk_dec;
               O_STK_WE             <= 1'b1;
               O_STK_ADR            <= stk_dec;
               O_STK_DAT            <= instr_pointer;
               instr_pointer        <= target;
               code_segment_pointer <= segment;
            end
            default: state <= exec_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);

   wire in_exec = (state == exec_pkg::ST_EXEC);

   // Sign-extended differences: overflow shows as the two top bits disagreeing
   wire [16:0] sdiff_w = {opnd_a[15], opnd_a} - {opnd_b[15], opnd_b};
   wire [8:0]  sdiff_b = {opnd_a[7], opnd_a[7:0]} - {opnd_b[7], opnd_b[7:0]};

   a_bit_xor_flags: assert property (in_exec && op == exec_pkg::OP_BIT_XOR |=>
      flags == {1'b0, !($past(opnd_a[0]) | $past(opnd_b[0])),
                $past(opnd_a[0]) | $past(opnd_b[0]), $past(opnd_a[0]) & $past(opnd_b[0]),
                $past(opnd_a[0]) ^ $past(opnd_b[0])})
      else $error("bit xor flags wrong");

   a_bit_xor_dest: assert property (in_exec && op == exec_pkg::OP_BIT_XOR |=>
      opnd_a[0] == ($past(opnd_a[0]) ^ $past(opnd_b[0])))
      else $error("bit xor result wrong");

   a_abs_call_push: assert property (in_exec && is_cond && cond |=>
      O_STK_WE && O_STK_ADR == $past(stk_dec) && O_STK_DAT == $past(instr_pointer)
      && instr_pointer == $past(target) && stack_ptr == $past(stk_dec))
      else $error("taken call push wrong");

   a_call_skip_quiet: assert property (in_exec && is_cond && !cond |=>
      !O_STK_WE && $stable(instr_pointer) && $stable(stack_ptr))
      else $error("untaken call changed state");

   a_predict_score: assert property (in_exec && op == exec_pkg::OP_CALL_ABS |=>
      mispred == ($past(cond) == $past(pred_nt)))
      else $error("prediction score wrong");

   a_rel_target: assert property (in_exec && op == exec_pkg::OP_CALL_REL |=>
      instr_pointer == 16'($past(instr_pointer) + $past(rel_off))
      && O_STK_DAT == $past(instr_pointer) && O_STK_WE)
      else $error("relative call target wrong");

   sequence seg_first_push;
      O_STK_WE && O_STK_DAT == $past(seg_word);
   endsequence
   sequence seg_second_push;
      O_STK_WE && O_STK_DAT == $past(instr_pointer, 2)
      && code_segment_pointer == $past(segment, 2) && instr_pointer == $past(target, 2);
   endsequence
   a_seg_push_order: assert property (in_exec && op == exec_pkg::OP_CALL_SEG |=>
      seg_first_push ##1 seg_second_push)
      else $error("segment call order wrong");

   a_call_flags_kept: assert property (in_exec && is_call |=> $stable(flags)[*2])
      else $error("call touched flags");

   a_compare_word_flags: assert property (in_exec && op == exec_pkg::OP_COMPARE_WORD |=>
      flags[`FLG_C] == ($past(opnd_a) < $past(opnd_b))
      && flags[`FLG_Z] == ($past(opnd_a) == $past(opnd_b))
      && flags[`FLG_E] == ($past(opnd_b) == `WORD_MIN_NEG) && $stable(opnd_a))
      else $error("word compare flags wrong");

   a_compare_byte_flags: assert property (in_exec && op == exec_pkg::OP_COMPARE_BYTE |=>
      flags[`FLG_E] == ($past(opnd_b[7:0]) == `BYTE_MIN_NEG)
      && flags[`FLG_C] == ($past(opnd_a[7:0]) < $past(opnd_b[7:0])) && $stable(opnd_a))
      else $error("byte compare flags wrong");

   a_compare_word_sign: assert property (in_exec && op == exec_pkg::OP_COMPARE_WORD |=>
      flags[`FLG_V] == $past(sdiff_w[16] ^ sdiff_w[15])
      && flags[`FLG_N] == $past(sdiff_w[15]))
      else $error("word compare sign flags wrong");

   a_compare_byte_sign: assert property (in_exec && op == exec_pkg::OP_COMPARE_BYTE |=>
      flags[`FLG_V] == $past(sdiff_b[8] ^ sdiff_b[7]) && flags[`FLG_N] == $past(sdiff_b[7])
      && flags[`FLG_Z] == ($past(opnd_a[7:0]) == $past(opnd_b[7:0])))
      else $error("byte compare sign flags wrong");

   a_rel_push_addr: assert property (in_exec && op == exec_pkg::OP_CALL_REL |=>
      O_STK_ADR == 16'($past(stack_ptr) - `STACK_STEP) && stack_ptr == O_STK_ADR)
      else $error("relative call push address wrong");

   a_wb_ack_pulse: assert property (bus_req && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK)
      else $error("ack not a single pulse");

endmodule

// ### tb/test_call_and_compare_execution.sv
// Self-checking bench for the call and compare execution unit, driven through Wishbone; pushes and busy are watched at their own ports.
// Assumes the unit acknowledges each request within a few cycles and reports busy in STATUS.
`timescale 1ns/1ps
`include "exec_consts.svh"

module test_call_and_compare_execution;
   logic        clk;
   logic        rst;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        stk_we;
   logic [15:0] stk_adr;
   logic [15:0] stk_dat;
   logic        busy;
   int          num_errors;
   int          checks_done;
   int          busy_cycles;
   logic [3:0]  bsel;
   logic [31:0] pushes [$];

   call_and_compare_execution u_call_and_compare_execution (
      .I_SYS_CLK (clk),
      .I_RST     (rst),
      .I_WB_CYC  (cyc),
      .I_WB_STB  (stb),
      .I_WB_WE   (we),
      .I_WB_ADR  (adr),
      .I_WB_SEL  (sel),
      .I_WB_DAT  (wdat),
      .O_WB_DAT  (rdat),
      .O_WB_ACK  (ack),
      .O_STK_WE  (stk_we),
      .O_STK_ADR (stk_adr),
      .O_STK_DAT (stk_dat),
      .O_BUSY    (busy)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Pushes and busy are short pulses, so they are logged as they happen
   always @(posedge clk) begin
      if (stk_we === 1'b1) begin
         pushes.push_back({stk_adr, stk_dat});
      end
      if (busy === 1'b1) begin
         busy_cycles++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= bsel;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      check({31'h0, ack}, 32'h1, "acknowledge");
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask

   function automatic logic [31:0] cmd(input exec_pkg::opcode_e op, input logic c,
                                       input logic p, input logic [7:0] disp);
      return {16'h0000, disp, 3'b000, p, c, 3'(op)};
   endfunction

   // Polling STATUS keeps the master free of any fixed execution latency
   task automatic run(input logic [31:0] c);
      logic [31:0] s;
      int          n;
      int          b;
      b = busy_cycles;
      wr(`ADR_COMMAND, c);
      n = 0;
      do begin
         rd(`ADR_STATUS, s);
         n++;
      end while (s[`STS_BUSY] !== 1'b0 && n < 20);
      check({31'h0, s[`STS_BUSY]}, 32'h0, "busy");
      check(busy_cycles - b, (c[2:0] == 3'(exec_pkg::OP_CALL_SEG)) ? 2 : 1, "busy cycles");
   endtask

   function automatic logic [4:0] flags(input logic [15:0] a, input logic [15:0] b,
                                        input logic bm);
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] r;
      int          t;
      t = bm ? 7 : 15;
      x = bm ? {8'h00, a[7:0]} : a;
      y = bm ? {8'h00, b[7:0]} : b;
      r = x - y;
      return {y == (bm ? {8'h00, `BYTE_MIN_NEG} : `WORD_MIN_NEG),
              bm ? r[7:0] == 8'h00 : r == 16'h0000,
              (x[t] != y[t]) && (r[t] != x[t]), x < y, r[t]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] q;
      rd(`ADR_STATUS, q);
      check(q, 32'h0, "status after reset");
      rd(`ADR_STACK_PTR, q);
      check(q, 32'h0, "stack pointer after reset");
      rd(8'h40, q);
      check(q, 32'h0, "unmapped read");
      wr(`ADR_STATUS, 32'h0000_061F);
      rd(`ADR_STATUS, q);
      check(q, 32'h0, "status is read only");
      bsel = 4'h1;
      wr(`ADR_OPND_A, 32'h0000_BBAA);
      wr(`ADR_COMMAND, cmd(exec_pkg::OP_COMPARE_WORD, 1'b0, 1'b0, 8'h00));
      bsel = 4'hF;
      rd(`ADR_OPND_A, q);
      check(q, 32'h0000_00AA, "low lane write");
      rd(`ADR_COMMAND, q);
      check(q, 32'h0, "partial command dropped");
      run(cmd(exec_pkg::OP_NONE, 1'b0, 1'b0, 8'h00));
      rd(`ADR_STATUS, q);
      check(q, 32'h0, "status after no-op");
      $display("reset test done");
   endtask

   task automatic t_bit_xor();
      logic [31:0] q;
      logic        a;
      logic        b;
      for (int i = 0; i < 4; i++) begin
         a = i[0];
         b = i[1];
         wr(`ADR_OPND_A, {31'h0000_52D2, a});
         wr(`ADR_OPND_B, {31'h0, b});
         run(cmd(exec_pkg::OP_BIT_XOR, 1'b0, 1'b0, 8'h00));
         rd(`ADR_STATUS, q);
         check({27'h0, q[4:0]}, {27'h0, 1'b0, ~(a | b), a | b, a & b, a ^ b}, "xor flags");
         rd(`ADR_OPND_A, q);
         check(q, {31'h0000_52D2, a ^ b}, "xor result");
      end
      $display("bit xor test done");
   endtask

   task automatic t_compare();
      logic [15:0] ta [10];
      logic [15:0] tb [10];
      logic [31:0] q;
      logic        bm;
      ta = '{16'h0005, 16'h0003, 16'h8000, 16'h7FFF, 16'h0000, 16'h1234,
             16'h0080, 16'h0000, 16'h12FF, 16'h0001};
      tb = '{16'h0003, 16'h0005, 16'h0001, 16'hFFFF, 16'h8000, 16'h1234,
             16'h0001, 16'h0080, 16'h3401, 16'h0002};
      for (int i = 0; i < 10; i++) begin
         bm = (i >= 6);
         wr(`ADR_OPND_A, {16'h0000, ta[i]});
         wr(`ADR_OPND_B, {16'h0000, tb[i]});
         run(cmd(bm ? exec_pkg::OP_COMPARE_BYTE : exec_pkg::OP_COMPARE_WORD, 1'b0, 1'b0, 8'h00));
         rd(`ADR_STATUS, q);
         check({27'h0, q[4:0]}, {27'h0, flags(ta[i], tb[i], bm)}, "compare flags");
         rd(`ADR_OPND_A, q);
         check(q, {16'h0000, ta[i]}, "first operand kept");
         rd(`ADR_OPND_B, q);
         check(q, {16'h0000, tb[i]}, "second operand kept");
      end
      $display("compare test done");
   endtask

   // Every call starts from stack 0100 and return point 1234 with flags 17 left by a compare
   task automatic do_call(input logic [31:0] c, input logic [15:0] ins, input logic [15:0] stk,
                          input logic tk, input logic mis, input int np);
      logic [31:0] q;
      pushes.delete();
      wr(`ADR_STACK_PTR, 32'h0000_0100);
      wr(`ADR_INSTR_PTR, 32'h0000_1234);
      run(c);
      rd(`ADR_STACK_PTR, q);
      check(q, {16'h0000, stk}, "stack pointer");
      rd(`ADR_INSTR_PTR, q);
      check(q, {16'h0000, ins}, "instruction pointer");
      rd(`ADR_STATUS, q);
      check(q & 32'h0000_061F, {21'h0, mis, tk, 9'h017}, "status after call");
      check(pushes.size(), np, "push count");
      if (np > 0) begin
         check(pushes[0], {16'h00FE, (np == 2) ? 16'h0005 : 16'h1234}, "first push");
      end
      if (np == 2) begin
         check(pushes[1], 32'h00FC_1234, "second push");
      end
   endtask

   task automatic t_call_intersegment();
      logic [31:0] q;
      logic        c;
      logic        p;
      wr(`ADR_OPND_A, 32'h0000_0000);
      wr(`ADR_OPND_B, 32'h0000_8000);
      run(cmd(exec_pkg::OP_COMPARE_WORD, 1'b0, 1'b0, 8'h00));
      wr(`ADR_TARGET, 32'h0000_4000);
      for (int i = 0; i < 4; i++) begin
         c = i[0];
         p = i[1];
         do_call(cmd(exec_pkg::OP_CALL_ABS, c, p, 8'h00), c ? 16'h4000 : 16'h1234,
                 c ? 16'h00FE : 16'h0100, c, c == p, c ? 1 : 0);
         do_call(cmd(exec_pkg::OP_CALL_IND, c, p, 8'h00), c ? 16'h4000 : 16'h1234,
                 c ? 16'h00FE : 16'h0100, c, 1'b0, c ? 1 : 0);
      end
      do_call(cmd(exec_pkg::OP_CALL_REL, 1'b0, 1'b0, 8'hF0), 16'h1214, 16'h00FE, 1'b1, 1'b0, 1);
      do_call(cmd(exec_pkg::OP_CALL_REL, 1'b0, 1'b0, 8'h7F), 16'h1332, 16'h00FE, 1'b1, 1'b0, 1);
      wr(`ADR_CODE_SEG, 32'h0000_0005);
      wr(`ADR_SEGMENT, 32'h0000_002A);
      do_call(cmd(exec_pkg::OP_CALL_SEG, 1'b0, 1'b0, 8'h00), 16'h4000, 16'h00FC, 1'b1, 1'b0, 2);
      rd(`ADR_CODE_SEG, q);
      check(q, 32'h0000_002A, "new code segment");
      $display("call test done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      num_errors = 0;
      checks_done = 0;
      busy_cycles = 0;
      bsel = 4'hF;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_bit_xor();
      t_compare();
      t_call_intersegment();
      test_done();
   end

   // The whole run needs under a thousand cycles; twenty times that is a hang
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("Error at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
